// ==== inc/amd_defines.vh ====
// Purpose: Constants for the addressing-mode decoder.
// Assumes: Opcode layout below is local to this core.
// Notes:   Column = opcode[7:4], operation = opcode[3:0].
`ifndef AMD_DEFINES_VH
`define AMD_DEFINES_VH

// Prefix bytes
`define AMD_PFX_Y        8'h90
`define AMD_PFX_IY       8'h91
`define AMD_PFX_IND      8'h92

// Opcode columns
`define AMD_COL_INH      4'h0
`define AMD_COL_IMM      4'h1
`define AMD_COL_DIR_S    4'h2
`define AMD_COL_DIR_L    4'h3
`define AMD_COL_IDX_0    4'h4
`define AMD_COL_IDX_S    4'h5
`define AMD_COL_IDX_L    4'h6
`define AMD_COL_REL      4'h7

// Decoded addressing modes
`define AMD_M_INH        4'h0
`define AMD_M_IMM        4'h1
`define AMD_M_DIR_S      4'h2
`define AMD_M_DIR_L      4'h3
`define AMD_M_IDX_0      4'h4
`define AMD_M_IDX_S      4'h5
`define AMD_M_IDX_L      4'h6
`define AMD_M_IND_S      4'h7
`define AMD_M_IND_L      4'h8
`define AMD_M_IIX_S      4'h9
`define AMD_M_IIX_L      4'hA
`define AMD_M_REL_D      4'hB
`define AMD_M_REL_I      4'hC

// Operations in memory columns; codes from RMW_FIRST up are short only
`define AMD_OP_LD        4'h0
`define AMD_OP_CP        4'h1
`define AMD_OP_BIT_COMPARE_OP 4'h2
`define AMD_OP_AND       4'h3
`define AMD_OP_XOR       4'h5
`define AMD_OP_ADC       4'h6
`define AMD_OP_SBC       4'h9
`define AMD_OP_CLR       4'hA
`define AMD_OP_INC       4'hB
`define AMD_OP_DEC       4'hC
`define AMD_OP_TEST_SIGN_ZERO_OP 4'hD
`define AMD_OP_CPL       4'hE
`define AMD_OP_SHIFT     4'hF
`define AMD_RMW_FIRST    4'hA
`define AMD_OP_RELATIVE_CALL_OP 4'hF

// Inherent operations, also bit positions of the one-hot strobe bus
`define AMD_INH_NOP      4'h0
`define AMD_INH_TRAP     4'h1
`define AMD_INH_WAIT_FOR_INTERRUPT_OP  4'h2
`define AMD_INH_HALT     4'h3
`define AMD_INH_RET      4'h4
`define AMD_INH_INTERRUPT_RETURN_OP    4'h5
`define AMD_INH_SET_IRQ_MASK_OP        4'h6
`define AMD_INH_CLEAR_IRQ_MASK_OP      4'h7
`define AMD_INH_SET_CARRY_OP           4'h8
`define AMD_INH_CLEAR_CARRY_OP         4'h9
`define AMD_INH_STACK_POINTER_RESET_OP 4'hA
`define AMD_INH_MUL      4'hB
`define AMD_INH_COUNT    12

// Interrupt mask levels
`define AMD_IMASK_SET    2'h3
`define AMD_IMASK_CLR    2'h0

// Functional groups
`define AMD_G_LOAD       4'h0
`define AMD_G_STACK      4'h1
`define AMD_G_INCDEC     4'h2
`define AMD_G_CMP        4'h3
`define AMD_G_LOGIC      4'h4
`define AMD_G_ARITH      4'h7
`define AMD_G_SHIFT      4'h8
`define AMD_G_JUMP       4'h9
`define AMD_G_COND       4'hA
`define AMD_G_INT        4'hB
`define AMD_G_FLAG       4'hC

`define AMD_LEN_MAX      3'h7
`endif

// ==== core/amd_ea_adder.v ====
// Purpose: Effective address and relative target arithmetic.
// Assumes: All inputs stable during the decoder's calculate cycle.
// Notes:   Purely combinational; sums wrap at 16 bits.
`timescale 1ns/100ps
module amd_ea_adder (
  input  wire [15:0] base,
  input  wire [7:0]  index,
  input  wire        add_index,
  input  wire [15:0] pc_next,
  input  wire [7:0]  rel_off,
  output wire [15:0] ea,
  output wire [15:0] target
);
  wire [15:0] idx_ext;
  wire [15:0] off_ext;

  // Index is unsigned, so a byte base plus index tops out at 1FE
  assign idx_ext = add_index ? {8'h00, index} : 16'h0000;
  assign ea      = base + idx_ext;
  // Offset is signed two's complement
  assign off_ext = {{8{rel_off[7]}}, rel_off};
  assign target  = pc_next + off_ext;
endmodule

// ==== core/amd_decoder.v ====
// Purpose: Addressing-mode decoder for an 8-bit core.
// Assumes: Bytes arrive in order on the fetch stream; pointer reads
//          are answered on the memory port with an acknowledge.
// Notes:   One result pulse per instruction, two cycles after the
//          last byte or pointer read.
`timescale 1ns/100ps
`include "amd_defines.vh"
module amd_decoder (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  fetch_data,
  input  wire        fetch_valid,
  output wire        fetch_ready,
  input  wire [15:0] pc_base,
  input  wire [7:0]  x_index,
  input  wire [7:0]  y_index,
  output wire        mem_rd_req,
  output wire [15:0] mem_rd_addr,
  input  wire [7:0]  mem_rd_data,
  input  wire        mem_rd_ack,
  output reg         dec_valid,
  output reg         dec_illegal,
  output reg  [3:0]  dec_mode,
  output reg  [3:0]  dec_op,
  output reg         dec_use_y,
  output reg  [2:0]  dec_length,
  output reg  [3:0]  dec_group,
  output reg  [15:0] dec_ea,
  output reg  [7:0]  dec_operand,
  output reg  [15:0] dec_target,
  output reg  [11:0] dec_inh_ops,
  output reg         imask_wr,
  output reg  [1:0]  imask_level
);
  localparam [5:0] ST_OPC  = 6'h01;
  localparam [5:0] ST_OP1  = 6'h02;
  localparam [5:0] ST_OP2  = 6'h04;
  localparam [5:0] ST_PTR1 = 6'h08;
  localparam [5:0] ST_PTR2 = 6'h10;
  localparam [5:0] ST_CALC = 6'h20;

  reg  [5:0]  state;
  reg  [5:0]  next_state;
  reg         pfx_y;
  reg         pfx_iy;
  reg         pfx_ind;
  reg         pfx_dup;
  reg  [7:0]  opcode;
  reg  [3:0]  mode;
  reg         use_y;
  reg         illegal;
  reg  [1:0]  need;
  reg  [2:0]  len;
  reg  [15:0] word;
  reg  [15:0] ptr;
  reg  [3:0]  d_mode;
  reg         d_use_y;
  reg         d_bad;
  reg  [1:0]  d_need;
  reg  [3:0]  g_code;
  wire        take;
  wire        is_pfx;
  wire        ptr_long;
  wire        ptr_mode;
  wire        add_idx;
  wire [15:0] base;
  wire [15:0] ea_sum;
  wire [15:0] tgt_sum;
  wire [15:0] pc_next;
  wire [7:0]  rel_off;

  assign take   = fetch_valid & fetch_ready;
  assign is_pfx = (fetch_data == `AMD_PFX_Y) |
                  (fetch_data == `AMD_PFX_IY) |
                  (fetch_data == `AMD_PFX_IND);

  // Handshakes: bytes only in fetch states, reads only in pointer states
  assign fetch_ready = (state == ST_OPC) | (state == ST_OP1) |
                       (state == ST_OP2);
  assign mem_rd_req  = (state == ST_PTR1) | (state == ST_PTR2);
  // Pointer address is one byte, zero-extended; word pointers are
  // read high byte first from addr then low byte from addr+1
  assign mem_rd_addr = (state == ST_PTR2) ?
                       ({8'h00, word[7:0]} + 16'h0001) :
                       {8'h00, word[7:0]};

  assign ptr_long = (mode == `AMD_M_IND_L) | (mode == `AMD_M_IIX_L);
  assign ptr_mode = ptr_long | (mode == `AMD_M_IND_S) |
                    (mode == `AMD_M_IIX_S) | (mode == `AMD_M_REL_I);

  // Opcode decode with prefix substitution and short-only checks
  always @* begin
    d_use_y = pfx_y | pfx_iy;
    d_bad   = pfx_dup;
    case (fetch_data[7:4])
      `AMD_COL_INH:   d_mode = `AMD_M_INH;
      `AMD_COL_IMM:   d_mode = `AMD_M_IMM;
      `AMD_COL_DIR_S: d_mode = `AMD_M_DIR_S;
      `AMD_COL_DIR_L: d_mode = `AMD_M_DIR_L;
      `AMD_COL_IDX_0: d_mode = `AMD_M_IDX_0;
      `AMD_COL_IDX_S: d_mode = `AMD_M_IDX_S;
      `AMD_COL_IDX_L: d_mode = `AMD_M_IDX_L;
      `AMD_COL_REL:   d_mode = `AMD_M_REL_D;
      default: begin
        d_mode = `AMD_M_INH;
        d_bad  = 1'b1;
      end
    endcase
    // Y prefix refused only on the relative column; other columns accept it
    if (pfx_y && (d_mode > `AMD_M_IDX_L))
      d_bad = 1'b1;
    if (pfx_ind) begin
      if (d_mode == `AMD_M_DIR_S)
        d_mode = `AMD_M_IND_S;
      else if (d_mode == `AMD_M_DIR_L)
        d_mode = `AMD_M_IND_L;
      else if (d_mode == `AMD_M_IDX_S)
        d_mode = `AMD_M_IIX_S;
      else if (d_mode == `AMD_M_IDX_L)
        d_mode = `AMD_M_IIX_L;
      else if (d_mode == `AMD_M_REL_D)
        d_mode = `AMD_M_REL_I;
      else
        d_bad = 1'b1;
    end
    if (pfx_iy) begin
      if (d_mode == `AMD_M_IDX_S)
        d_mode = `AMD_M_IIX_S;
      else if (d_mode == `AMD_M_IDX_L)
        d_mode = `AMD_M_IIX_L;
      else
        d_bad = 1'b1;
    end
    // Unused inherent codes are not instructions
    if ((d_mode == `AMD_M_INH) && (fetch_data[3:0] > `AMD_INH_MUL))
      d_bad = 1'b1;
    // Read-modify-write ops: no immediate and no long forms
    if ((d_mode != `AMD_M_INH) && (d_mode != `AMD_M_REL_D) &&
        (d_mode != `AMD_M_REL_I) &&
        (fetch_data[3:0] >= `AMD_RMW_FIRST) &&
        ((d_mode == `AMD_M_IMM) || (d_mode == `AMD_M_DIR_L) ||
         (d_mode == `AMD_M_IDX_L) || (d_mode == `AMD_M_IND_L) ||
         (d_mode == `AMD_M_IIX_L)))
      d_bad = 1'b1;
    // Bytes that follow the opcode in the stream
    case (d_mode)
      `AMD_M_INH, `AMD_M_IDX_0:
        d_need = 2'h0;
      `AMD_M_DIR_L, `AMD_M_IDX_L:
        d_need = 2'h2;
      default:
        d_need = 2'h1;
    endcase
  end

  // Functional group of the latched instruction
  always @* begin
    if (mode == `AMD_M_INH) begin
      case (opcode[3:0])
        `AMD_INH_NOP, `AMD_INH_RET: g_code = `AMD_G_JUMP;
        `AMD_INH_TRAP, `AMD_INH_WAIT_FOR_INTERRUPT_OP,
        `AMD_INH_HALT, `AMD_INH_INTERRUPT_RETURN_OP:
          g_code = `AMD_G_INT;
        `AMD_INH_STACK_POINTER_RESET_OP:
          g_code = `AMD_G_STACK;
        `AMD_INH_MUL:               g_code = `AMD_G_ARITH;
        default:                    g_code = `AMD_G_FLAG;
      endcase
    end else if ((mode == `AMD_M_REL_D) || (mode == `AMD_M_REL_I)) begin
      if (opcode[3:0] == `AMD_OP_RELATIVE_CALL_OP)
        g_code = `AMD_G_JUMP;
      else
        g_code = `AMD_G_COND;
    end else begin
      case (opcode[3:0])
        `AMD_OP_LD, `AMD_OP_CLR:    g_code = `AMD_G_LOAD;
        `AMD_OP_CP, `AMD_OP_BIT_COMPARE_OP,
        `AMD_OP_TEST_SIGN_ZERO_OP:  g_code = `AMD_G_CMP;
        `AMD_OP_INC, `AMD_OP_DEC:   g_code = `AMD_G_INCDEC;
        `AMD_OP_SHIFT:              g_code = `AMD_G_SHIFT;
        `AMD_OP_CPL:                g_code = `AMD_G_LOGIC;
        default: begin
          if (opcode[3:0] <= `AMD_OP_XOR)
            g_code = `AMD_G_LOGIC;
          else
            g_code = `AMD_G_ARITH;
        end
      endcase
    end
  end

  // Operand sources for the address arithmetic
  assign base = ptr_mode ? ptr : word;
  assign add_idx = (mode == `AMD_M_IDX_0) | (mode == `AMD_M_IDX_S) |
                   (mode == `AMD_M_IDX_L) | (mode == `AMD_M_IIX_S) |
                   (mode == `AMD_M_IIX_L);
  assign rel_off = (mode == `AMD_M_REL_I) ? ptr[7:0] : word[7:0];
  // Relative jumps count from the instruction that follows
  assign pc_next = pc_base + {13'h0000, len};

  amd_ea_adder i_amd_ea_adder (
    .base      (base),
    .index     (use_y ? y_index : x_index),
    .add_index (add_idx),
    .pc_next   (pc_next),
    .rel_off   (rel_off),
    .ea        (ea_sum),
    .target    (tgt_sum)
  );

  // Sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_OPC: begin
        if (take && !is_pfx)
          next_state = (d_need == 2'h0) ? ST_CALC : ST_OP1;
      end
      ST_OP1: begin
        if (take) begin
          if (need == 2'h2)
            next_state = ST_OP2;
          else if (ptr_mode)
            next_state = ST_PTR1;
          else
            next_state = ST_CALC;
        end
      end
      ST_OP2: begin
        if (take)
          next_state = ST_CALC;
      end
      ST_PTR1: begin
        if (mem_rd_ack)
          next_state = ptr_long ? ST_PTR2 : ST_CALC;
      end
      ST_PTR2: begin
        if (mem_rd_ack)
          next_state = ST_CALC;
      end
      default: next_state = ST_OPC;
    endcase
  end

  // Byte capture, prefix memory and length count
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_OPC;
      pfx_y   <= 1'b0;
      pfx_iy  <= 1'b0;
      pfx_ind <= 1'b0;
      pfx_dup <= 1'b0;
      opcode  <= 8'h00;
      mode    <= `AMD_M_INH;
      use_y   <= 1'b0;
      illegal <= 1'b0;
      need    <= 2'h0;
      len     <= 3'h0;
      word    <= 16'h0000;
      ptr     <= 16'h0000;
    end else begin
      state <= next_state;
      // Every byte taken from the stream lengthens the instruction, up to a count of 7
      if (take && (len != `AMD_LEN_MAX))
        len <= len + 3'h1;
      if ((state == ST_OPC) && take) begin
        if (is_pfx) begin
          // A second prefix is not a defined combination
          pfx_dup <= pfx_y | pfx_iy | pfx_ind;
          pfx_y   <= (fetch_data == `AMD_PFX_Y);
          pfx_iy  <= (fetch_data == `AMD_PFX_IY);
          pfx_ind <= (fetch_data == `AMD_PFX_IND);
        end else begin
          opcode  <= fetch_data;
          mode    <= d_mode;
          use_y   <= d_use_y;
          illegal <= d_bad;
          need    <= d_need;
          word    <= 16'h0000;
          ptr     <= 16'h0000;
        end
      end
      // Word operands arrive high byte first
      if ((state == ST_OP1) && take) begin
        if (need == 2'h2)
          word <= {fetch_data, 8'h00};
        else
          word <= {8'h00, fetch_data};
      end
      if ((state == ST_OP2) && take)
        word[7:0] <= fetch_data;
      if ((state == ST_PTR1) && mem_rd_ack) begin
        if (ptr_long)
          ptr <= {mem_rd_data, 8'h00};
        else
          ptr <= {8'h00, mem_rd_data};
      end
      if ((state == ST_PTR2) && mem_rd_ack)
        ptr[7:0] <= mem_rd_data;
      // Prefixes and count belong to one instruction only
      if (state == ST_CALC) begin
        pfx_y   <= 1'b0;
        pfx_iy  <= 1'b0;
        pfx_ind <= 1'b0;
        pfx_dup <= 1'b0;
        len     <= 3'h0;
      end
    end
  end

  // Result registers, loaded and strobed in the calculate cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid   <= 1'b0;
      dec_illegal <= 1'b0;
      dec_mode    <= `AMD_M_INH;
      dec_op      <= 4'h0;
      dec_use_y   <= 1'b0;
      dec_length  <= 3'h0;
      dec_group   <= `AMD_G_LOAD;
      dec_ea      <= 16'h0000;
      dec_operand <= 8'h00;
      dec_target  <= 16'h0000;
      dec_inh_ops <= 12'h000;
      imask_wr    <= 1'b0;
      imask_level <= `AMD_IMASK_CLR;
    end else begin
      dec_valid   <= (state == ST_CALC);
      imask_wr    <= 1'b0;
      dec_inh_ops <= 12'h000;
      if (state == ST_CALC) begin
        dec_illegal <= illegal;
        dec_mode    <= mode;
        dec_op      <= opcode[3:0];
        dec_use_y   <= use_y;
        dec_length  <= len;
        dec_group   <= g_code;
        dec_ea      <= ea_sum;
        dec_operand <= word[7:0];
        dec_target  <= tgt_sum;
        if ((mode == `AMD_M_INH) && !illegal) begin
          dec_inh_ops[opcode[3:0]] <= 1'b1;
          if (opcode[3:0] == `AMD_INH_SET_IRQ_MASK_OP) begin
            imask_wr    <= 1'b1;
            imask_level <= `AMD_IMASK_SET;
          end
          if (opcode[3:0] == `AMD_INH_CLEAR_IRQ_MASK_OP) begin
            imask_wr    <= 1'b1;
            imask_level <= `AMD_IMASK_CLR;
          end
        end
      end
    end
  end
endmodule

// ==== testbench/amd_checker.sv ====
// Purpose: Port assertions for the addressing-mode decoder.
// Assumes: Bound onto every amd_decoder instance.
// Notes:   Only relations visible at the ports are watched.
`timescale 1ns/100ps
`include "amd_defines.vh"
module amd_checker (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        fetch_ready,
  input wire        mem_rd_req,
  input wire [15:0] mem_rd_addr,
  input wire        mem_rd_ack,
  input wire        dec_valid,
  input wire        dec_illegal,
  input wire [3:0]  dec_mode,
  input wire [3:0]  dec_op,
  input wire        dec_use_y,
  input wire [2:0]  dec_length,
  input wire [15:0] dec_ea,
  input wire [11:0] dec_inh_ops,
  input wire        imask_wr,
  input wire [1:0]  imask_level
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Legal results grouped by mode family
  wire good = dec_valid && !dec_illegal;
  wire m_short = dec_mode == `AMD_M_DIR_S || dec_mode == `AMD_M_IND_S ||
                 dec_mode == `AMD_M_IDX_0;
  wire m_reach = dec_mode == `AMD_M_IDX_S || dec_mode == `AMD_M_IIX_S;
  wire m_long = dec_mode == `AMD_M_IMM || dec_mode == `AMD_M_DIR_L ||
                dec_mode == `AMD_M_IDX_L || dec_mode == `AMD_M_IND_L ||
                dec_mode == `AMD_M_IIX_L;

  a_calc_first: assert property (
    dec_valid |-> !$past(fetch_ready)) else $error("no calc before result");
  a_inh_onehot: assert property (
    good && dec_mode == `AMD_M_INH |-> $onehot(dec_inh_ops))
    else $error("inherent strobe not one-hot");
  a_inh_length: assert property (
    good && dec_mode == `AMD_M_INH |-> dec_length == (dec_use_y ? 3'h2 : 3'h1))
    else $error("inherent length wrong");
  a_mask_set: assert property (
    imask_wr && dec_inh_ops[`AMD_INH_SET_IRQ_MASK_OP] |->
      imask_level == `AMD_IMASK_SET)
    else $error("mask set level wrong");
  a_mask_clr: assert property (
    imask_wr && dec_inh_ops[`AMD_INH_CLEAR_IRQ_MASK_OP] |->
      imask_level == `AMD_IMASK_CLR)
    else $error("mask clear level wrong");
  a_imm_length: assert property (
    good && dec_mode == `AMD_M_IMM |-> dec_length == (dec_use_y ? 3'h3 : 3'h2))
    else $error("immediate length wrong");
  a_short_page: assert property (
    good && m_short |-> dec_ea[15:8] == 8'h00) else $error("short ea off page");
  a_index_reach: assert property (
    good && m_reach |-> dec_ea <= 16'h01fe) else $error("short index reach");
  a_long_short: assert property (
    good && m_long |-> dec_op < `AMD_RMW_FIRST) else $error("long rmw accepted");
  a_ptr_hold: assert property (
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("pointer request dropped");

  // Main scenarios reached
  c_mask: cover property (imask_wr);
  c_ptr: cover property (mem_rd_req && mem_rd_ack);
  c_iix: cover property (good && dec_mode == `AMD_M_IIX_L);
endmodule
bind amd_decoder amd_checker i_amd_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .fetch_ready(fetch_ready),
  .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_ack(mem_rd_ack), .dec_valid(dec_valid),
  .dec_illegal(dec_illegal), .dec_mode(dec_mode), .dec_op(dec_op),
  .dec_use_y(dec_use_y), .dec_length(dec_length), .dec_ea(dec_ea),
  .dec_inh_ops(dec_inh_ops), .imask_wr(imask_wr),
  .imask_level(imask_level));

// ==== testbench/amd_mem_model.sv ====
// Purpose: Data memory answering pointer reads.
// Assumes: Byte at an address is its low byte xor a5.
// Notes:   Answer latency set by lat; bus scrambled between answers.
`timescale 1ns/100ps
module amd_mem_model (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        mem_rd_req,
  input  wire [15:0] mem_rd_addr,
  input  wire [3:0]  lat,
  output reg  [7:0]  mem_rd_data,
  output reg         mem_rd_ack
);
  reg [3:0] wait_cnt;
  // Toggle the idle bus so a stale byte never passes for a fresh one
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt    <= 4'h0;
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= 8'h00;
    end else if (mem_rd_req && !mem_rd_ack && wait_cnt == lat) begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= mem_rd_addr[7:0] ^ 8'ha5;
    end else begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
      wait_cnt    <= (mem_rd_req && !mem_rd_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== testbench/amd_decoder_tb.sv ====
// Purpose: Self-checking bench for the addressing-mode decoder.
// Assumes: Pointer memory model holds address xor a5.
// Notes:   Inputs move 1 ns after the rising edge.
`timescale 1ns/100ps
`include "amd_defines.vh"
module amd_decoder_tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  fetch_data = 8'h00;
  reg         fetch_valid = 1'b0;
  reg  [15:0] pc_base = 16'h1000;
  reg  [7:0]  x_index = 8'h00;
  reg  [7:0]  y_index = 8'h00;
  reg  [3:0]  lat = 4'h0;
  wire        fetch_ready, mem_rd_req, mem_rd_ack, dec_valid;
  wire        dec_illegal, dec_use_y, imask_wr;
  wire [15:0] mem_rd_addr, dec_ea, dec_target;
  wire [7:0]  mem_rd_data, dec_operand;
  wire [3:0]  dec_mode, dec_op, dec_group;
  wire [2:0]  dec_length;
  wire [11:0] dec_inh_ops;
  wire [1:0]  imask_level;
  integer     err_count = 0;
  integer     check_count = 0;

  amd_decoder i_amd_decoder (
    .ref_clk(ref_clk), .rst_n(rst_n), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
    .pc_base(pc_base), .x_index(x_index), .y_index(y_index),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_rd_ack(mem_rd_ack),
    .dec_valid(dec_valid), .dec_illegal(dec_illegal),
    .dec_mode(dec_mode), .dec_op(dec_op), .dec_use_y(dec_use_y),
    .dec_length(dec_length), .dec_group(dec_group), .dec_ea(dec_ea),
    .dec_operand(dec_operand), .dec_target(dec_target),
    .dec_inh_ops(dec_inh_ops), .imask_wr(imask_wr),
    .imask_level(imask_level));
  amd_mem_model i_amd_mem_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_data(mem_rd_data),
    .mem_rd_ack(mem_rd_ack));

  // 20 MHz core clock
  always #25 ref_clk = ~ref_clk;

  task tick;
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask

  // Offer n bytes, oldest in the top byte, then wait for the result pulse
  task issue(input [31:0] b, input integer n);
    integer k, w;
    begin
      for (k = n - 1; k >= 0; k = k - 1) begin
        fetch_data = b[8*k +: 8];
        fetch_valid = 1'b1;
        w = 0;
        while (fetch_ready !== 1'b1 && w < 100) begin
          tick;
          w = w + 1;
        end
        tick;
      end
      fetch_valid = 1'b0;
      w = 0;
      while (dec_valid !== 1'b1 && w < 100) begin
        tick;
        w = w + 1;
      end
      chk("dec_valid", 16'h0001, {15'h0000, dec_valid});
    end
  endtask

  task res(input [3:0] m, input [2:0] l, input [15:0] ea);
    begin
      chk("dec_mode", {12'h000, m}, {12'h000, dec_mode});
      chk("dec_length", {13'h0000, l}, {13'h0000, dec_length});
      chk("dec_ea", ea, dec_ea);
    end
  endtask

  task t_inherent;
    integer c;
    reg [47:0] grp;
    reg [15:0] g;
    reg        m;
    begin
      grp = 48'h71cc_ccb9_bbb9;
      for (c = 0; c < `AMD_INH_COUNT; c = c + 1) begin
        g = {12'h000, grp[4*c +: 4]};
        m = (c == 6) || (c == 7);
        issue({28'h0000_000, c[3:0]}, 1);
        chk("dec_length", 16'h0001, {13'h0000, dec_length});
        chk("dec_inh_ops", 16'h0001 << c, {4'h0, dec_inh_ops});
        chk("dec_group", g, {12'h000, dec_group});
        chk("imask_wr", {15'h0000, m}, {15'h0000, imask_wr});
        if (m) begin
          g = (c == 6) ? 16'h0003 : 16'h0000;
          chk("imask_level", g, {14'h0000, imask_level});
        end
      end
      issue(32'h0000_000c, 1);
      chk("dec_illegal", 16'h0001, {15'h0000, dec_illegal});
      issue(32'h0000_9008, 2);
      chk("dec_length", 16'h0002, {13'h0000, dec_length});
    end
  endtask

  task t_immediate;
    integer o;
    reg [39:0] grp;
    reg [15:0] g;
    begin
      // Expected group per operation code, operation 0 in the low nibble
      grp = 40'h7777_4443_30;
      for (o = 0; o < 10; o = o + 1) begin
        g = {12'h000, grp[4*o +: 4]};
        issue({16'h0000, 4'h1, o[3:0], 8'h5a}, 2);
        chk("dec_group", g, {12'h000, dec_group});
        chk("dec_operand", 16'h005a, {8'h00, dec_operand});
        chk("dec_illegal", 16'h0000, {15'h0000, dec_illegal});
      end
      issue(32'h0000_1a5a, 2);
      chk("dec_illegal", 16'h0001, {15'h0000, dec_illegal});
      issue(32'h0090_105a, 3);
      chk("dec_use_y", 16'h0001, {15'h0000, dec_use_y});
    end
  endtask

  task t_forms;
    integer o;
    reg     b;
    begin
      for (o = 0; o < 16; o = o + 1) begin
        b = (o >= 10);
        issue({8'h00, 4'h3, o[3:0], 16'h1234}, 3);
        chk("dec_illegal", {15'h0000, b}, {15'h0000, dec_illegal});
        chk("dec_op", {12'h000, o[3:0]}, {12'h000, dec_op});
        issue({16'h0000, 4'h2, o[3:0], 8'h10}, 2);
        chk("dec_illegal", 16'h0000, {15'h0000, dec_illegal});
      end
    end
  endtask

  task t_direct_indexed;
    begin
      issue(32'h0000_20ff, 2);
      res(`AMD_M_DIR_S, 3'h2, 16'h00ff);
      issue(32'h0031_1234, 3);
      res(`AMD_M_DIR_L, 3'h3, 16'h1234);
      x_index = 8'hff;
      issue(32'h0000_0040, 1);
      res(`AMD_M_IDX_0, 3'h1, 16'h00ff);
      issue(32'h0000_50ff, 2);
      res(`AMD_M_IDX_S, 3'h2, 16'h01fe);
      x_index = 8'h20;
      issue(32'h0060_12f0, 3);
      res(`AMD_M_IDX_L, 3'h3, 16'h1310);
      y_index = 8'h80;
      issue(32'h0090_5010, 3);
      res(`AMD_M_IDX_S, 3'h3, 16'h0090);
    end
  endtask

  task t_indirect;
    begin
      issue(32'h0092_2010, 3);
      res(`AMD_M_IND_S, 3'h3, 16'h00b5);
      lat = 4'h3;
      issue(32'h0092_3040, 3);
      res(`AMD_M_IND_L, 3'h3, 16'he5e4);
      x_index = 8'hff;
      lat = 4'h1;
      issue(32'h0092_5033, 3);
      res(`AMD_M_IIX_S, 3'h3, 16'h0195);
      x_index = 8'h10;
      issue(32'h0092_6020, 3);
      res(`AMD_M_IIX_L, 3'h3, 16'h8594);
      y_index = 8'h70;
      issue(32'h0091_5033, 3);
      res(`AMD_M_IIX_S, 3'h3, 16'h0106);
      issue(32'h9092_2010, 4);
      chk("dec_illegal", 16'h0001, {15'h0000, dec_illegal});
    end
  endtask

  task t_relative;
    begin
      issue(32'h0000_7380, 2);
      chk("dec_target", 16'h0f82, dec_target);
      chk("dec_group", 16'h000a, {12'h000, dec_group});
      issue(32'h0000_7f7f, 2);
      chk("dec_target", 16'h1081, dec_target);
      chk("dec_group", 16'h0009, {12'h000, dec_group});
      lat = 4'h2;
      // Offset byte read from 05 is a0, zero-extended on the address
      issue(32'h0092_7305, 3);
      res(`AMD_M_REL_I, 3'h3, 16'h00a0);
      chk("dec_target", 16'h0fa3, dec_target);
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Watchdog: roughly thirty times the expected run length
  initial begin
    #400000;
    err_count = err_count + 1;
    print_verdict;
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    tick;
    t_inherent;
    t_immediate;
    t_forms;
    t_direct_indexed;
    t_indirect;
    t_relative;
    print_verdict;
  end
endmodule
